// ### logic/asp_serial_port.sv
`default_nettype none
`include "asp_defines.svh"

// ==========================================================================
// Functional notes
// - Self-clocking: drive clock after either frame sync falls, data only after receive frame sync falls.
// - External clocking: drive data only after receive frame sync falls.
// - Result ready goes low when a new result word is available.
// - Result ready returns high after a full output word is shifted out.
// - Result ready also goes low when calibration finishes.
// - Result read drives data only if result ready was low at frame start.
// - Write bits valid while transmit sync low, sampled on rising clock.
// - Results natural binary for unipolar, offset binary for bipolar.
// - One data line carries writes and reads of all registers.
// - Write with register select low targets the 24-bit configuration word.
// - Read with register select low returns the configuration word.
// - Configuration word updates only after all 24 bits are written.
// - Clock pulses after the 24th in a write frame are ignored.
// - Transmit sync active low; self-clocking drives the clock after it falls.
// - Normal mode, the reset default, reads results with select high.
module asp_serial_port (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        self_clock_i,
   input  wire logic        receive_frame_sync_n_i,
   input  wire logic        transmit_frame_sync_n_i,
   input  wire logic        register_select_i,
   input  wire logic        serial_clock_i,
   output logic             serial_clock_o,
   output logic             serial_clock_oe_n_o,
   input  wire logic        serial_data_i,
   output logic             serial_data_o,
   output logic             serial_data_oe_n_o,
   input  wire logic [23:0] result_i,
   input  wire logic        result_valid_i,
   input  wire logic        cal_done_i,
   output logic             result_ready_n_o,
   output logic [23:0]      configuration_word_o,
   output logic [23:0]      zero_coef_o,
   output logic [23:0]      full_coef_o
);
   asp_pin_if pins ();

   asp_pin_sync u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .rfs_n_i   (receive_frame_sync_n_i),
      .tfs_n_i   (transmit_frame_sync_n_i),
      .sel_i     (register_select_i),
      .serial_data_io_i   (serial_data_i),
      .sclk_i    (serial_clock_i),
      .pins      (pins)
   );

   asp_pkg::asp_state_t   state_reg;
   asp_pkg::asp_src_t     src_reg;
   logic [`ASP_CNT_BITS-1:0] bit_cnt_reg;
   logic [23:0]           shift_reg;
   logic [23:0]           result_reg;
   logic                  drive_reg;
   logic [2:0]            div_reg;
   logic                  gen_clk_reg;
   logic                  gen_rise;
   logic                  gen_fall;
   logic [1:0]            rise_dly_reg;
   logic                  clk_rise;
   logic                  clk_fall;
   logic                  word_done;
   logic                  load_res;
   logic [2:0]            mode;

   // Converts a raw two's complement result into the polarity coding in force.
   function automatic logic [23:0] asp_code(input logic [23:0] raw, input logic uni);
      asp_code = uni ? raw : {~raw[23], raw[22:0]};
   endfunction

   assign mode = configuration_word_o[`ASP_MODE_MSB:`ASP_MODE_LSB];

   // ==========================================================================
   // Link clock: generated internally in self-clocking mode, else sampled.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_reg     <= 3'h0;
         gen_clk_reg <= 1'b1;
      end else if (self_clock_i && state_reg != asp_pkg::ASP_IDLE && !word_done) begin
         if (div_reg == 3'(`ASP_SCLK_HALF_CYC - 1)) begin
            div_reg     <= 3'h0;
            gen_clk_reg <= ~gen_clk_reg;
         end else begin
            div_reg <= div_reg + 3'h1;
         end
      end else begin
         div_reg     <= 3'h0;
         gen_clk_reg <= 1'b1;
      end
   end

   assign gen_rise  = self_clock_i && !gen_clk_reg &&
                      div_reg == 3'(`ASP_SCLK_HALF_CYC - 1);
   assign gen_fall  = self_clock_i && gen_clk_reg && state_reg != asp_pkg::ASP_IDLE &&
                      !word_done && div_reg == 3'(`ASP_SCLK_HALF_CYC - 1);
   assign clk_rise  = self_clock_i ? rise_dly_reg[1] : pins.sclk_rise;
   assign clk_fall  = self_clock_i ? gen_fall : pins.sclk_fall;
   assign word_done = bit_cnt_reg == 5'(`ASP_WORD_BITS);

   // Self-clocked write bits pass the pin synchroniser, so the sampling strobe
   // trails the generated rise by two cycles to meet the synchronised data.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rise_dly_reg <= 2'h0;
      end else begin
         rise_dly_reg <= {rise_dly_reg[0], gen_rise};
      end
   end

   // Clock pin driven only inside a self-clocked frame.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         serial_clock_o      <= 1'b1;
         serial_clock_oe_n_o <= 1'b1;
      end else begin
         serial_clock_o      <= gen_clk_reg;
         serial_clock_oe_n_o <= !(self_clock_i && state_reg != asp_pkg::ASP_IDLE);
      end
   end

   // ==========================================================================
   // Frame engine: write and read frames, bit counting and register updates.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg            <= asp_pkg::ASP_IDLE;
         src_reg              <= asp_pkg::ASP_SRC_CFG;
         bit_cnt_reg          <= 5'h00;
         shift_reg            <= 24'h00_0000;
         drive_reg            <= 1'b0;
         configuration_word_o <= `ASP_CFG_RESET;
         zero_coef_o          <= 24'h00_0000;
         full_coef_o          <= 24'h00_0000;
      end else begin
         unique case (state_reg)
            asp_pkg::ASP_IDLE: begin
               bit_cnt_reg <= 5'h00;
               drive_reg   <= 1'b0;
               if (!pins.tfs_n) begin
                  state_reg <= asp_pkg::ASP_WRITE;
                  src_reg   <= !pins.sel ? asp_pkg::ASP_SRC_CFG :
                               mode == `ASP_MODE_ZS_COEF ? asp_pkg::ASP_SRC_ZS :
                               asp_pkg::ASP_SRC_FS;
               end else if (!pins.rfs_n) begin
                  state_reg <= asp_pkg::ASP_READ;
                  if (!pins.sel) begin
                     src_reg   <= asp_pkg::ASP_SRC_CFG;
                     shift_reg <= configuration_word_o;
                     drive_reg <= 1'b1;
                  end else if (mode == `ASP_MODE_ZS_COEF) begin
                     src_reg   <= asp_pkg::ASP_SRC_ZS;
                     shift_reg <= zero_coef_o;
                     drive_reg <= 1'b1;
                  end else if (mode == `ASP_MODE_FS_COEF) begin
                     src_reg   <= asp_pkg::ASP_SRC_FS;
                     shift_reg <= full_coef_o;
                     drive_reg <= 1'b1;
                  end else begin
                     src_reg   <= asp_pkg::ASP_SRC_DATA;
                     shift_reg <= result_reg;
                     drive_reg <= !result_ready_n_o;
                  end
               end
            end
            asp_pkg::ASP_WRITE: begin
               if (pins.tfs_n) begin
                  state_reg <= asp_pkg::ASP_IDLE;
                  if (word_done) begin
                     unique case (src_reg)
                        asp_pkg::ASP_SRC_CFG:  configuration_word_o <= shift_reg;
                        asp_pkg::ASP_SRC_ZS:   zero_coef_o          <= shift_reg;
                        asp_pkg::ASP_SRC_FS:   full_coef_o          <= shift_reg;
                        asp_pkg::ASP_SRC_DATA: shift_reg            <= shift_reg;
                     endcase
                  end
               end else if (clk_rise && !word_done) begin
                  shift_reg   <= {shift_reg[22:0], pins.serial_data_io};
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
               end
            end
            asp_pkg::ASP_READ: begin
               if (pins.rfs_n) begin
                  state_reg <= asp_pkg::ASP_IDLE;
                  drive_reg <= 1'b0;
               end else if (clk_fall && !word_done) begin
                  shift_reg   <= {shift_reg[22:0], 1'b0};
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
               end
            end
            default: state_reg <= asp_pkg::ASP_IDLE;
         endcase
      end
   end

   // Data pin: MSB first, driven only while a read frame is open.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         serial_data_o      <= 1'b0;
         serial_data_oe_n_o <= 1'b1;
      end else begin
         serial_data_o      <= shift_reg[23];
         serial_data_oe_n_o <= !(drive_reg && state_reg == asp_pkg::ASP_READ &&
                                 !pins.rfs_n);
      end
   end

   // ==========================================================================
   // Result word latch and ready flag.
   assign load_res = result_valid_i && state_reg != asp_pkg::ASP_READ;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         result_reg <= 24'h00_0000;
      end else if (load_res) begin
         result_reg <= asp_code(result_i, configuration_word_o[`ASP_UNIPOLAR_BIT]);
      end
   end

   // New word or calibration end sets ready low; a whole result read clears it.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         result_ready_n_o <= 1'b1;
      end else if (load_res || cal_done_i) begin
         result_ready_n_o <= 1'b0;
      end else if (state_reg == asp_pkg::ASP_READ && src_reg == asp_pkg::ASP_SRC_DATA &&
                   drive_reg && word_done) begin
         result_ready_n_o <= 1'b1;
      end
   end
endmodule

`default_nettype wire

// ### logic/asp_defines.svh
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

// ==========================================================================
// Word lengths and bit counts.
`define ASP_WORD_BITS        24
`define ASP_CNT_BITS         5
`define ASP_LAST_BIT         5'h17
`define ASP_CFG_RESET        24'h00_0000
// Configuration word fields: operating mode at the top, polarity at bit 12.
`define ASP_MODE_MSB         23
`define ASP_MODE_LSB         21
`define ASP_UNIPOLAR_BIT     12
`define ASP_MODE_NORMAL      3'h0
`define ASP_MODE_ZS_COEF     3'h6
`define ASP_MODE_FS_COEF     3'h7
// Self-clocking divider: link clock half period in reference clock cycles.
`define ASP_SCLK_HALF_NS     200
`define ASP_CLK_PERIOD_NS    50
`define ASP_SCLK_HALF_CYC    (`ASP_SCLK_HALF_NS / `ASP_CLK_PERIOD_NS)

`endif

// ### logic/asp_pkg.sv
`default_nettype none

// ==========================================================================
// Types shared by the serial port modules.
package asp_pkg;
   typedef enum logic [1:0] {
      ASP_IDLE  = 2'b00,
      ASP_WRITE = 2'b01,
      ASP_READ  = 2'b10
   } asp_state_t;

   typedef enum logic [1:0] {
      ASP_SRC_CFG  = 2'b00,
      ASP_SRC_DATA = 2'b01,
      ASP_SRC_ZS   = 2'b10,
      ASP_SRC_FS   = 2'b11
   } asp_src_t;
endpackage

`default_nettype wire

// ### logic/asp_pin_if.sv
`default_nettype none

// ==========================================================================
// Synchronised pin levels and link clock edges handed to the port engine.
interface asp_pin_if;
   logic rfs_n;
   logic tfs_n;
   logic sel;
   logic serial_data_io;
   logic sclk_rise;
   logic sclk_fall;

   modport sync (output rfs_n, tfs_n, sel, serial_data_io, sclk_rise, sclk_fall);
   modport core (input rfs_n, tfs_n, sel, serial_data_io, sclk_rise, sclk_fall);
endinterface

`default_nettype wire

// ### logic/asp_pin_sync.sv
`default_nettype none

// ==========================================================================
// Three-stage synchronisers; a change is taken once stages two and three agree.
module asp_pin_sync (
   input  wire logic ref_clk_i,
   input  wire logic reset_n_i,
   input  wire logic rfs_n_i,
   input  wire logic tfs_n_i,
   input  wire logic sel_i,
   input  wire logic serial_data_io_i,
   input  wire logic sclk_i,
   asp_pin_if.sync   pins
);
   logic [4:0] s1_reg;
   logic [4:0] s2_reg;
   logic [4:0] s3_reg;
   logic [4:0] lvl_reg;

   // Three flip-flop chain for every pin; frame inputs idle high.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s1_reg <= 5'h1b;
         s2_reg <= 5'h1b;
         s3_reg <= 5'h1b;
      end else begin
         s1_reg <= {rfs_n_i, tfs_n_i, sel_i, serial_data_io_i, sclk_i};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Filtered level follows only where the second and third stages agree.
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lvl_reg <= 5'h1b;
      end else begin
         lvl_reg <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg ^ s3_reg));
      end
   end

   assign pins.rfs_n     = lvl_reg[4];
   assign pins.tfs_n     = lvl_reg[3];
   assign pins.sel       = lvl_reg[2];
   assign pins.serial_data_io     = lvl_reg[1];
   assign pins.sclk_rise = (s2_reg[0] & s3_reg[0]) & ~lvl_reg[0];
   assign pins.sclk_fall = ~(s2_reg[0] | s3_reg[0]) & lvl_reg[0];
endmodule

`default_nettype wire

// ### test/asp_serial_port_monitor.sv
`default_nettype none

// ==========================================================================
// Port checker for the serial port, bound to the port's top module.
module asp_serial_port_monitor (
   input wire logic        ref_clk_i,
   input wire logic        reset_n_i,
   input wire logic        self_clock_i,
   input wire logic        receive_frame_sync_n_i,
   input wire logic        transmit_frame_sync_n_i,
   input wire logic        register_select_i,
   input wire logic        serial_clock_oe_n_o,
   input wire logic        serial_data_oe_n_o,
   input wire logic        result_valid_i,
   input wire logic        cal_done_i,
   input wire logic        result_ready_n_o,
   input wire logic [23:0] configuration_word_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   // Drivers turn on only inside a frame that allows them.
   clk_owner_a: assert property (!serial_clock_oe_n_o |-> self_clock_i)
      else $error("clock driven in external mode");
   clk_late_a: assert property ($fell(serial_clock_oe_n_o) |->
      !$past(receive_frame_sync_n_i, 3) || !$past(transmit_frame_sync_n_i, 3))
      else $error("clock driven before a frame");
   data_late_a: assert property ($fell(serial_data_oe_n_o) |->
      !$past(receive_frame_sync_n_i, 3)) else $error("data driven before a read frame");
   ready_gate_a: assert property ($fell(serial_data_oe_n_o) && register_select_i &&
      configuration_word_o[23:21] == 3'h0 |-> !result_ready_n_o)
      else $error("result driven with no new word");
   write_quiet_a: assert property (!transmit_frame_sync_n_i &&
      !$past(transmit_frame_sync_n_i, 6) |-> serial_data_oe_n_o)
      else $error("data driven during a write");

   // Ready flag follows new words, calibration ends and completed reads.
   ready_set_a: assert property (result_valid_i && receive_frame_sync_n_i &&
      $past(receive_frame_sync_n_i, 8) |-> ##[1:3] !result_ready_n_o)
      else $error("ready missing after result");
   cal_ready_a: assert property (cal_done_i && receive_frame_sync_n_i |->
      ##[1:3] !result_ready_n_o) else $error("ready missing after calibration");
   ready_clear_a: assert property ($rose(result_ready_n_o) |->
      register_select_i && !$past(receive_frame_sync_n_i, 2))
      else $error("ready cleared outside a result read");

   // The word changes only just after a write frame closes.
   word_hold_a: assert property ($changed(configuration_word_o) |->
      transmit_frame_sync_n_i && !$past(transmit_frame_sync_n_i, 8))
      else $error("word changed outside a write end");
endmodule

bind asp_serial_port asp_serial_port_monitor mon_u (.*);

`default_nettype wire

// ### test/asp_host_model.sv
`default_nettype none

// ==========================================================================
// Host controller model: frame syncs, external link clock and write data.
module asp_host_model (
   input  wire logic clk_i,
   input  wire logic self_i,
   input  wire logic dev_clk_i,
   input  wire logic dev_clk_oe_n_i,
   input  wire logic dev_data_i,
   input  wire logic dev_data_oe_n_i,
   output var logic  rfs_n_o,
   output var logic  tfs_n_o,
   output var logic  sel_o,
   output wire logic clk_o,
   output wire logic data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk;
   logic hd;
   logic hd_en;
   logic flip;
   int   hang;

   // Frames closed and the link clock idle high from time zero.
   initial begin
      {rfs_n_o, tfs_n_o, sel_o, hclk, hd, hd_en, flip, hang} = {5'h1b, 2'h0, 32'h0};
   end

   // A released data line toggles, so a stale level never passes for data.
   always @(negedge clk_i) flip <= ~flip;

   // Wire levels: the device wins while it enables its driver.
   assign clk_o  = !dev_clk_oe_n_i ? dev_clk_i : hclk;
   assign data_o = !dev_data_oe_n_i ? dev_data_i : (hd_en ? hd : flip);

   // Moves the external clock to a level, or waits for the device to do so.
   task automatic to_level(input logic lvl);
      int n;
      if (!self_i) begin
         repeat (2) @(negedge clk_i);
         hclk = lvl;
         repeat (2) @(negedge clk_i);
      end else begin
         for (n = 0; n < 200 && clk_o !== lvl; n++) @(negedge clk_i);
         if (n == 200) hang++;
      end
   endtask

   // One frame of n clock periods, writing wdata MSB first or reading rdata.
   task automatic xfer(input logic wr, sel, input logic [23:0] wdata, input int n,
                       output logic [23:0] rdata);
      int k;
      @(negedge clk_i);
      sel_o = sel;
      hd = wdata[23];
      hd_en = wr;
      if (wr) tfs_n_o = 1'b0;
      else rfs_n_o = 1'b0;
      if (!self_i) repeat (12) @(negedge clk_i);
      // A self-clocked read starts once the device has put its first bit out.
      if (self_i && !wr) begin
         for (k = 0; k < 200 && dev_data_oe_n_i; k++) @(negedge clk_i);
         if (k == 200) hang++;
      end
      for (int i = 0; i < n; i++) begin
         rdata = {rdata[22:0], data_o};
         to_level(1'b0);
         hd = (i < 24) ? wdata[23 - i] : flip;
         to_level(1'b1);
      end
      repeat (4) @(negedge clk_i);
      {rfs_n_o, tfs_n_o} = 2'h3;
      repeat (2) @(negedge clk_i);
      hd_en = 1'b0;
      repeat (12) @(negedge clk_i);
   endtask
endmodule

`default_nettype wire

// ### test/test_asp_serial_port.sv
`default_nettype none
`include "asp_defines.svh"

// ==========================================================================
// Self-checking bench for the serial port.
module test_asp_serial_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_i = 1'b0, reset_n_i = 1'b0, self_clock_i = 1'b0;
   logic result_valid_i = 1'b0, cal_done_i = 1'b0;
   logic [23:0] result_i = 24'h0, rd, w, t;
   logic [31:0] seed = 32'hd594_2616;
   int n_fail = 0, comparisons = 0;
   wire logic receive_frame_sync_n_i, transmit_frame_sync_n_i, register_select_i;
   wire logic serial_clock_i, serial_data_i, serial_clock_o, serial_clock_oe_n_o;
   wire logic serial_data_o, serial_data_oe_n_o, result_ready_n_o;
   wire logic [23:0] configuration_word_o, zero_coef_o, full_coef_o;

   // Reference clock, 50 ns period.
   always #25 ref_clk_i = ~ref_clk_i;

   // Device under test and the host on its far side.
   asp_serial_port dut_u (.*);
   asp_host_model host_u (.clk_i(ref_clk_i), .self_i(self_clock_i),
      .dev_clk_i(serial_clock_o), .dev_clk_oe_n_i(serial_clock_oe_n_o),
      .dev_data_i(serial_data_o), .dev_data_oe_n_i(serial_data_oe_n_o),
      .rfs_n_o(receive_frame_sync_n_i), .tfs_n_o(transmit_frame_sync_n_i),
      .sel_o(register_select_i), .clk_o(serial_clock_i), .data_o(serial_data_i));

   // Xorshift source of random words.
   function automatic logic [23:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[23:0];
   endfunction

   // Expected result coding: natural for unipolar, offset binary otherwise.
   function automatic logic [23:0] coded(input logic [23:0] r, input logic uni);
      return uni ? r : r ^ 24'h80_0000;
   endfunction

   // Comparison, verdict and bounded frame helpers.
   task automatic check(input string what, input logic [23:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic frame(input logic wr, s, input logic [23:0] d, input int n);
      host_u.xfer(wr, s, d, n, rd);
      if (host_u.hang != 0) begin
         n_fail++;
         wrap_up();
      end
   endtask
   task automatic pulse(input logic res, input logic [23:0] r);
      @(negedge ref_clk_i);
      result_i = r;
      {result_valid_i, cal_done_i} = {res, !res};
      @(negedge ref_clk_i);
      {result_valid_i, cal_done_i} = 2'h0;
      repeat (3) @(negedge ref_clk_i);
      check("ready low", result_ready_n_o, 24'h0);
   endtask

   // Main sequence.
   initial begin
      repeat (12) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      check("reset word", configuration_word_o, `ASP_CFG_RESET);
      check("reset ready", result_ready_n_o, 24'h1);
      for (int k = 0; k < 4; k++) begin
         self_clock_i = k[0];
         w = rnd() & 24'h1f_efff | {11'h0, k[1], 12'h0};
         frame(1'b1, 1'b0, w, 24);
         check("word", configuration_word_o, w);
         frame(1'b0, 1'b0, 24'h0, 24);
         check("word read", rd, w);
         self_clock_i = 1'b0;
         frame(1'b0, 1'b0, 24'h0, 24);
         check("word read", rd, w);
         t = rnd();
         pulse(1'b1, t);
         frame(1'b0, 1'b1, 24'h0, 24);
         check("result", rd, coded(t, k[1]));
         check("ready after read", result_ready_n_o, 24'h1);
      end
      t = rnd() & 24'h1f_ffff;
      frame(1'b1, 1'b0, ~t, 12);
      check("partial write", configuration_word_o, w);
      frame(1'b1, 1'b0, t, 30);
      check("long write", configuration_word_o, t);
      frame(1'b0, 1'b1, 24'h0, 24);
      check("ready idle", result_ready_n_o, 24'h1);
      pulse(1'b0, 24'h0);
      frame(1'b0, 1'b1, 24'h0, 24);
      check("ready after cal", result_ready_n_o, 24'h1);
      for (int m = 6; m < 8; m++) begin
         frame(1'b1, 1'b0, {m[2:0], 21'h0}, 24);
         t = rnd();
         frame(1'b1, 1'b1, t, 24);
         check("coefficient", (m == 6) ? zero_coef_o : full_coef_o, t);
         frame(1'b0, 1'b1, 24'h0, 24);
         check("coefficient read", rd, t);
      end
      wrap_up();
   end
endmodule

`default_nettype wire
